// ---- rtl/ftoi_pipe.sv ----
// three-stage float to signed integer converter with exception flags.
// assumes the caller has already folded the guard into inValid.
`timescale 1ns/1ps
module ftoi_pipe
  import guarded_ops_pkg::*;
(
  input wire logic clk,                  // processor clock
  input wire logic rst_n,                // async reset, active low
  input wire logic inValid,              // committed conversion request
  input wire logic [DEST_W-1:0] inDest,  // destination index
  input wire logic [DATA_W-1:0] inSrc,   // single-precision source
  input wire logic [1:0] roundMode,      // rounding mode from status word
  output wb_s outWb,                     // result, three cycles later
  output fflags_s outFlags               // flags, aligned with outWb
);

  typedef struct packed {
    logic [DATA_W-1:0] data;
    fflags_s flags;
  } conv_s;

  // full conversion; pipelined by register stages around it
  function automatic conv_s convert(input logic [DATA_W-1:0] f, input logic [1:0] rm);
    logic sign;
    logic [7:0] ex;
    logic [22:0] man;
    logic [63:0] fix;
    logic [DATA_W-1:0] ipart;
    logic [DATA_W-1:0] frac;
    logic inc;
    logic [DATA_W:0] mag;
    conv_s r;
    sign = f[31];
    ex = f[30:23];
    man = f[22:0];
    r = '0;
    fix = 64'h0;
    if (ex == FP_EXP_ALL1) begin
      r.flags.inv = 1'b1;
      r.data = (man != 23'h0) ? WORD_ZERO : (sign ? INT_NEG_MAX : INT_POS_MAX);
    end else if (ex == FP_EXP_ZERO) begin
      r.flags.zero_substitution_flag = (man != 23'h0);
      r.data = WORD_ZERO;
    end else if (ex >= FP_EXP_OVF) begin
      // only -2^31 itself fits
      r.data = sign ? INT_NEG_MAX : INT_POS_MAX;
      r.flags.inv = !(sign && ex == FP_EXP_OVF && man == 23'h0);
    end else begin
      // tiny magnitudes keep only a sticky bit below one half
      if (ex < FP_EXP_TINY)
        fix = 64'h1;
      else
        fix = {41'h1, man} << (ex - FP_EXP_TINY);
      ipart = fix[63:32];
      frac = fix[31:0];
      case (rm)
        RM_NEAREST: inc = frac[31] & ((|frac[30:0]) | ipart[0]);
        RM_ZERO: inc = 1'b0;
        RM_POS: inc = !sign & (|frac);
        RM_NEG: inc = sign & (|frac);
        default: inc = 1'b0;
      endcase
      mag = {1'b0, ipart} + {32'h0, inc};
      if (!sign && mag > {1'b0, INT_POS_MAX}) begin
        r.flags.inv = 1'b1;
        r.data = INT_POS_MAX;
      end else if (sign && mag > {1'b0, INT_NEG_MAX}) begin
        r.flags.inv = 1'b1;
        r.data = INT_NEG_MAX;
      end else begin
        r.flags.inx = |frac;
        r.data = sign ? (~mag[DATA_W-1:0] + 32'h1) : mag[DATA_W-1:0];
      end
    end
    return r;
  endfunction

  logic s1Valid_r;
  logic [DEST_W-1:0] s1Dest_r;
  logic [DATA_W-1:0] s1Src_r;
  logic [1:0] s1Rm_r;
  logic s2Valid_r;
  logic [DEST_W-1:0] s2Dest_r;
  conv_s s2Conv_r;

  // stage one: capture operand and rounding mode at issue
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1Valid_r <= 1'b0;
      s1Dest_r <= '0;
      s1Src_r <= WORD_ZERO;
      s1Rm_r <= RM_NEAREST;
    end else begin
      s1Valid_r <= inValid;
      s1Dest_r <= inDest;
      s1Src_r <= inSrc;
      s1Rm_r <= roundMode;
    end
  end

  // stage two: convert
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s2Valid_r <= 1'b0;
      s2Dest_r <= '0;
      s2Conv_r <= '0;
    end else begin
      s2Valid_r <= s1Valid_r;
      s2Dest_r <= s1Dest_r;
      s2Conv_r <= convert(s1Src_r, s1Rm_r);
    end
  end

  // stage three: result and flags leave together
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outWb <= WB_IDLE;
      outFlags <= '0;
    end else begin
      outWb <= '{valid: s2Valid_r, dest: s2Dest_r, data: s2Conv_r.data};
      outFlags <= s2Valid_r ? s2Conv_r.flags : '0;
    end
  end

endmodule // ftoi_pipe

// ---- rtl/guarded_ops_pkg.sv ----
// package for the guarded execution unit: operation codes, issue and
// writeback carriers, status word layout, slot numbers and float constants.
// assumes a 32-bit datapath and a five-slot issue scheme numbered 1 to 5.
package guarded_ops_pkg;

  localparam int DATA_W = 32;
  localparam int DEST_W = 7;
  localparam int SLOT_W = 3;

  typedef enum logic [1:0] {OP_CARRY, OP_CYCLES, OP_ABS, OP_FTOI} op_e;
  typedef logic [SLOT_W-1:0] slot_t;

  // issue slots
  localparam slot_t SLOT_FIRST = 3'h1;
  localparam slot_t SLOT_LAST = 3'h5;
  localparam slot_t SLOT_CYCLES = 3'h3;
  localparam slot_t SLOT_ABS_A = 3'h1;
  localparam slot_t SLOT_ABS_B = 3'h3;
  localparam slot_t SLOT_FTOI_A = 3'h1;
  localparam slot_t SLOT_FTOI_B = 3'h4;

  // rounding mode encodings held in the status word
  localparam logic [1:0] RM_NEAREST = 2'h0;
  localparam logic [1:0] RM_ZERO = 2'h1;
  localparam logic [1:0] RM_POS = 2'h2;
  localparam logic [1:0] RM_NEG = 2'h3;

  // single-precision field limits
  localparam logic [7:0] FP_EXP_ALL1 = 8'hFF;
  localparam logic [7:0] FP_EXP_OVF = 8'h9E;  // magnitude at least 2^31
  localparam logic [7:0] FP_EXP_TINY = 8'h76; // below this, under 2^-9
  localparam logic [7:0] FP_EXP_ZERO = 8'h00;

  localparam logic [DATA_W-1:0] INT_NEG_MAX = 32'h80000000;
  localparam logic [DATA_W-1:0] INT_POS_MAX = 32'h7FFFFFFF;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;

  typedef struct packed {
    logic inv;
    logic ovf;
    logic unf;
    logic inx;
    logic zero_substitution_flag;
  } fflags_s;

  typedef struct packed {
    logic [1:0] roundMode;
    logic stallCountSel;
    fflags_s flags;
  } processor_status_word_s;

  localparam processor_status_word_s PROCESSOR_STATUS_WORD_RESET = '0;

  typedef struct packed {
    logic valid;
    op_e op;
    slot_t slot;
    logic guardPresent;
    logic guardLsb;
    logic [DEST_W-1:0] dest;
    logic [DATA_W-1:0] srcA;
    logic [DATA_W-1:0] srcB;
  } issue_s;

  typedef struct packed {
    logic valid;
    logic [DEST_W-1:0] dest;
    logic [DATA_W-1:0] data;
  } wb_s;

  localparam wb_s WB_IDLE = '0;

endpackage

// ---- rtl/guarded_ops_unit.sv ----
// execution unit for guarded carry, cycle-count read, clipped absolute
// value and float to integer conversion, with the status word and the
// master/slave cycle counter. assumes the issue word, stall and jump
// signals come from logic on the same clock; each operation class has its
// own writeback port so results of different latencies never collide.
`timescale 1ns/1ps
module guarded_ops_unit
  import guarded_ops_pkg::*;
#(
  parameter int CNT_W = 64 // width of the cycle counter
) (
  input wire logic clk,                 // processor clock, 100 MHz
  input wire logic rst_n,               // processor reset, async, active low
  input issue_s issue,                  // operation presented this cycle
  output logic issueAccept,             // op and slot form a legal issue
  input wire logic stall,               // processor stalled this cycle
  input wire logic jumpOk,              // successful interruptible jump
  input wire logic pcswWrEn,            // explicit status word write
  input processor_status_word_s pcswWrData,              // data for that write
  input wire logic extFlagsValid,       // other float units report flags
  input fflags_s extFlags,              // their flag updates
  output processor_status_word_s processor_status_word,                   // current status word
  output logic [CNT_W-1:0] ccMaster,    // running master counter
  output logic [CNT_W-1:0] ccSlave,     // sampled slave copy
  output wb_s aluWb,                    // carry result
  output wb_s cycWb,                    // cycle read result
  output wb_s absWb,                    // clipped absolute result
  output wb_s fltWb                     // float to int result
);

  // the cycle read takes its low word, so anything narrower is useless
  if (CNT_W < 2 * DATA_W) begin : g_cnt_w_check
    $error("guarded_ops_unit: CNT_W must be at least twice the data width");
  end

  // which slots each operation may occupy
  function automatic logic slotLegal(input op_e op, input slot_t slot);
    logic ok;
    ok = 1'b0;
    case (op)
      OP_CARRY: ok = (slot >= SLOT_FIRST) && (slot <= SLOT_LAST);
      OP_CYCLES: ok = (slot == SLOT_CYCLES);
      OP_ABS: ok = (slot == SLOT_ABS_A) || (slot == SLOT_ABS_B);
      OP_FTOI: ok = (slot == SLOT_FTOI_A) || (slot == SLOT_FTOI_B);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // signed absolute value clipped to the positive maximum
  function automatic logic [DATA_W-1:0] clipAbs(input logic [DATA_W-1:0] v);
    logic [DATA_W-1:0] r;
    if (!v[DATA_W-1])
      r = v;
    else if (v == INT_NEG_MAX)
      r = INT_POS_MAX;
    else
      r = ~v + 32'h1;
    return r;
  endfunction

  logic guardTrue;
  logic commit;
  logic [DATA_W:0] carrySum;
  logic absS1Valid_r;
  logic [DEST_W-1:0] absS1Dest_r;
  logic [DATA_W-1:0] absS1Src_r;
  logic [CNT_W-1:0] ccMaster_nxt;
  processor_status_word_s processor_status_word_nxt;
  fflags_s fltFlags;
  logic fltFlagsValid;
  fflags_s flagSets;

  // handshake is combinational; a refused op simply does nothing
  assign issueAccept = issue.valid && slotLegal(issue.op, issue.slot);

  // an absent guard behaves as a true one
  assign guardTrue = !issue.guardPresent || issue.guardLsb;
  assign commit = issueAccept && guardTrue;

  // 33-bit sum so the top bit is the carry out
  assign carrySum = {1'b0, issue.srcA} + {1'b0, issue.srcB};

  // carry: one-cycle result
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aluWb <= WB_IDLE;
    end else begin
      aluWb.valid <= commit && issue.op == OP_CARRY;
      aluWb.dest <= issue.dest;
      aluWb.data <= {{(DATA_W-1){1'b0}}, carrySum[DATA_W]};
    end
  end

  // cycle read: one-cycle result from the slave copy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cycWb <= WB_IDLE;
    end else begin
      cycWb.valid <= commit && issue.op == OP_CYCLES;
      cycWb.dest <= issue.dest;
      cycWb.data <= ccSlave[DATA_W-1:0];
    end
  end

  // clipped absolute, first stage; the first source is never looked at,
  // software is expected to pass zero there
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      absS1Valid_r <= 1'b0;
      absS1Dest_r <= '0;
      absS1Src_r <= WORD_ZERO;
    end else begin
      absS1Valid_r <= commit && issue.op == OP_ABS;
      absS1Dest_r <= issue.dest;
      absS1Src_r <= issue.srcB;
    end
  end

  // clipped absolute, second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      absWb <= WB_IDLE;
    end else begin
      absWb.valid <= absS1Valid_r;
      absWb.dest <= absS1Dest_r;
      absWb.data <= clipAbs(absS1Src_r);
    end
  end

  // float to int runs three stages; guard folded in so nothing moves
  // through the flag path when the guard is false
  ftoi_pipe u_ftoi (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(commit && issue.op == OP_FTOI),
    .inDest(issue.dest),
    .inSrc(issue.srcA),
    .roundMode(processor_status_word.roundMode),
    .outWb(fltWb),
    .outFlags(fltFlags)
  );

  assign fltFlagsValid = fltWb.valid;

  // merge every flag source this cycle; all of them only ever set bits
  always_comb begin
    flagSets = '0;
    if (fltFlagsValid)
      flagSets = flagSets | fltFlags;
    if (extFlagsValid)
      flagSets = flagSets | extFlags;
  end

  // status word: a software write may clear flags, but a flag set in the
  // same cycle still lands so no exception is ever lost
  always_comb begin
    processor_status_word_nxt = processor_status_word;
    if (pcswWrEn)
      processor_status_word_nxt = pcswWrData;
    processor_status_word_nxt.flags = processor_status_word_nxt.flags | flagSets;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      processor_status_word <= PROCESSOR_STATUS_WORD_RESET;
    else
      processor_status_word <= processor_status_word_nxt;
  end

  // master counter: stall cycles count only when stall-count select is set
  always_comb begin
    ccMaster_nxt = ccMaster;
    if (processor_status_word.stallCountSel || !stall)
      ccMaster_nxt = ccMaster + {{(CNT_W-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ccMaster <= '0;
    else
      ccMaster <= ccMaster_nxt;
  end

  // slave copy: reset loads the (reset) master value, jumps resample it,
  // so a low/high read pair between jumps is one coherent sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ccSlave <= '0;
    else if (jumpOk)
      ccSlave <= ccMaster;
  end

endmodule // guarded_ops_unit

// ---- verification/guarded_ops_asserts.sv ----
// checker for the guarded execution unit: timing and value relations.
// assumes the package carriers and one clock with async active-low reset.
`timescale 1ns/1ps
module guarded_ops_asserts
  import guarded_ops_pkg::*;
#(
  parameter int CNT_W = 64 // counter width
) (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input issue_s issue, // issue word
  input wire logic issueAccept, // legal issue
  input wire logic stall, // stall
  input wire logic jumpOk, // jump taken
  input wire logic pcswWrEn, // status write
  input wire logic extFlagsValid, // ext flags valid
  input fflags_s extFlags, // ext flags
  input processor_status_word_s processor_status_word, // status word
  input wire logic [CNT_W-1:0] ccMaster, // master count
  input wire logic [CNT_W-1:0] ccSlave, // slave copy
  input wb_s aluWb, // carry result
  input wb_s cycWb, // cycle result
  input wb_s absWb, // abs result
  input wb_s fltWb // ftoi result
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic go;
  logic cOut;
  logic [32:0] sum;
  logic [4:0] fl;
  logic [4:0] ex;
  logic [31:0] absExp;
  logic [31:0] slaveLo;
  // committed issue and reference values, guard folded in
  assign go = issue.valid && issueAccept && (!issue.guardPresent || issue.guardLsb);
  assign sum = {1'b0, issue.srcA} + {1'b0, issue.srcB};
  assign cOut = sum[32];
  assign fl = processor_status_word.flags;
  assign ex = extFlags;
  assign slaveLo = ccSlave[31:0];
  assign absExp = issue.srcB == INT_NEG_MAX ? INT_POS_MAX : issue.srcB[31] ? -issue.srcB : issue.srcB;
  a_carry_bit: assert property (go && issue.op == OP_CARRY |=>
    aluWb.valid && aluWb.data == {31'h0, $past(cOut)}) else $error("carry result wrong");
  a_guard_off: assert property (issue.valid && issue.guardPresent && !issue.guardLsb
    && issue.op == OP_FTOI |-> ##3 !fltWb.valid) else $error("guarded conversion wrote");
  a_cyc_data: assert property (go && issue.op == OP_CYCLES && !jumpOk |=>
    cycWb.valid && cycWb.data == slaveLo) else $error("cycle read wrong");
  a_cyc_slot: assert property (issueAccept && issue.op == OP_CYCLES |->
    issue.slot == SLOT_CYCLES) else $error("cycle read in wrong slot");
  a_abs_clip: assert property (go && issue.op == OP_ABS |-> ##2
    absWb.valid && absWb.data == $past(absExp, 2)) else $error("abs result wrong");
  a_ftoi_lat: assert property (go && issue.op == OP_FTOI |-> ##3 fltWb.valid)
    else $error("conversion latency wrong");
  a_slave_hold: assert property (!jumpOk |=> $stable(ccSlave))
    else $error("slave changed without jump");
  a_slave_take: assert property (jumpOk |=> ccSlave == $past(ccMaster))
    else $error("slave missed master");
  a_master_step: assert property (processor_status_word.stallCountSel || !stall |=>
    ccMaster == $past(ccMaster) + 1'b1) else $error("master did not count");
  a_master_hold: assert property (!processor_status_word.stallCountSel && stall |=> $stable(ccMaster))
    else $error("master counted in stall");
  a_flag_sticky: assert property (!pcswWrEn |=> ($past(fl) & ~fl) == 5'h00)
    else $error("flag cleared without write");
  a_ext_merge: assert property (extFlagsValid |=> (fl & $past(ex)) == $past(ex))
    else $error("ext flags not merged");
endmodule // guarded_ops_asserts

bind guarded_ops_unit guarded_ops_asserts #(.CNT_W(CNT_W)) u_guarded_ops_asserts (.clk, .rst_n, .issue,
  .issueAccept, .stall, .jumpOk, .pcswWrEn, .extFlagsValid, .extFlags, .processor_status_word, .ccMaster, .ccSlave,
  .aluWb, .cycWb, .absWb, .fltWb);

// ---- verification/guarded_ops_unit_tb.sv ----
// self-checking bench for the guarded execution unit.
// assumes a 100 MHz clock and the checker bound from its own file.
`timescale 1ns/1ps
module guarded_ops_unit_tb;
  import guarded_ops_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  issue_s issue = '0;
  logic stall = 1'b0;
  logic jumpOk = 1'b0;
  logic pcswWrEn = 1'b0;
  processor_status_word_s pcswWrData = '0;
  logic extFlagsValid = 1'b0;
  fflags_s extFlags = '0;
  logic issueAccept;
  processor_status_word_s processor_status_word;
  logic [63:0] ccMaster, ccSlave, mExp, sExp;
  wb_s aluWb, cycWb, absWb, fltWb;
  logic selExp;
  logic [4:0] fExp = 5'h00;
  logic [7:0] okMask [4] = '{8'h3E, 8'h08, 8'h0A, 8'h12};
  logic [31:0] posRes [4] = '{32'h3, 32'h2, 32'h3, 32'h2};
  logic [31:0] negRes [4] = '{32'hFFFFFFFE, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFE};
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;

  guarded_ops_unit #(.CNT_W(64)) u_guarded_ops_unit (.clk, .rst_n, .issue, .issueAccept, .stall,
    .jumpOk, .pcswWrEn, .pcswWrData, .extFlagsValid, .extFlags, .processor_status_word, .ccMaster, .ccSlave,
    .aluWb, .cycWb, .absWb, .fltWb);

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard, far above the roughly 180 cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      n_fail++;
      end_sim();
    end
  end

  // counter mirror, fed from our own stimulus only
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mExp <= '0;
      sExp <= '0;
      selExp <= 1'b0;
    end else begin
      if (selExp || !stall) mExp <= mExp + 64'h1;
      if (jumpOk) sExp <= mExp;
      if (pcswWrEn) selExp <= pcswWrData.stallCountSel;
    end
  end
  always @(negedge clk) begin
    if (rst_n) begin
      check(ccMaster, mExp);
      check(ccSlave, sExp);
    end
  end

  // one issue, then its port, result and flags after the fixed latency
  task automatic run(input op_e op, input slot_t sl, input logic [1:0] g, input logic [31:0] a,
      input logic [31:0] b, input logic [31:0] exp, input logic [4:0] fl = 5'h00);
    wb_s w;
    logic c;
    c = (!g[1] || g[0]) && okMask[op][sl];
    @(posedge clk);
    issue <= '{1'b1, op, sl, g[1], g[0], 7'h05, a, b};
    @(posedge clk);
    issue.valid <= 1'b0;
    // the take edge already passed, so wait latency minus one more edges
    repeat (op == OP_ABS ? 1 : op == OP_FTOI ? 2 : 0) @(posedge clk);
    #1;
    w = op == OP_CARRY ? aluWb : op == OP_CYCLES ? cycWb : op == OP_ABS ? absWb : fltWb;
    if (c && op == OP_FTOI) fExp = fExp | fl;
    check(w.valid, c);
    if (c) check(w.data, exp);
    if (c) check(w.dest, 64'h05);
    // flags land with the register file write, one edge after the result shows
    @(posedge clk);
    #1;
    check(processor_status_word.flags, fExp);
  endtask

  // status write; a write replaces the flags
  task automatic wrPcsw(input logic [7:0] v);
    @(posedge clk);
    pcswWrEn <= 1'b1;
    pcswWrData <= processor_status_word_s'(v);
    @(posedge clk);
    pcswWrEn <= 1'b0;
    fExp = v[4:0];
  endtask

  initial begin
    repeat (5) @(posedge clk);
    check(processor_status_word, 8'h00);
    rst_n <= 1'b1;
    run(OP_CARRY, 3'h2, 2'b00, 32'h4, 32'hFFFFFFFC, 32'h1);
    run(OP_CARRY, 3'h5, 2'b00, 32'h2, 32'hFFFFFFFC, 32'h0);
    run(OP_CARRY, 3'h1, 2'b10, 32'h4, 32'hFFFFFFFC, 32'h1);
    run(OP_CARRY, 3'h4, 2'b11, 32'hFFFFFFFC, 32'hFFFFFFFC, 32'h1);
    // first source held at zero for every abs issue
    run(OP_ABS, 3'h1, 2'b00, 32'h0, 32'hFFFFFFFF, 32'h1);
    run(OP_ABS, 3'h3, 2'b00, 32'h0, 32'h80000000, 32'h7FFFFFFF);
    run(OP_ABS, 3'h1, 2'b11, 32'h0, 32'h80000001, 32'h7FFFFFFF);
    run(OP_ABS, 3'h3, 2'b10, 32'h0, 32'h80000001, 32'h0);
    run(OP_ABS, 3'h1, 2'b00, 32'h0, 32'h7FFFFFFF, 32'h7FFFFFFF);
    // every op in every slot, guard false so nothing commits
    for (int o = 0; o < 4; o++) begin
      for (int s = 0; s < 8; s++) begin
        @(posedge clk);
        issue <= '{1'b1, op_e'(o), s[2:0], 1'b1, 1'b0, 7'h0, 32'h0, 32'h0};
        #1;
        check(issueAccept, okMask[o][s]);
      end
    end
    @(posedge clk);
    issue.valid <= 1'b0;
    // stalls with stall counting off, then on
    for (int k = 0; k < 2; k++) begin
      wrPcsw({2'h0, k[0], 5'h00});
      stall <= 1'b1;
      repeat (3) @(posedge clk);
      stall <= 1'b0;
    end
    jumpOk <= 1'b1;
    @(posedge clk);
    jumpOk <= 1'b0;
    @(posedge clk);
    run(OP_CYCLES, 3'h3, 2'b00, 32'h0, 32'h0, sExp[31:0]);
    run(OP_CYCLES, 3'h2, 2'b00, 32'h0, 32'h0, 32'h0);
    run(OP_CYCLES, 3'h3, 2'b10, 32'h0, 32'h0, 32'h0);
    // one positive and one negative fraction in each rounding mode
    for (int m = 0; m < 4; m++) begin
      wrPcsw({m[1:0], 6'h00});
      run(OP_FTOI, 3'h1, 2'b00, 32'h40247AE1, 32'h0, posRes[m], 5'h02);
      run(OP_FTOI, 3'h4, 2'b00, 32'hBFC147AE, 32'h0, negRes[m], 5'h02);
    end
    wrPcsw(8'h00);
    run(OP_FTOI, 3'h1, 2'b10, 32'hFF7FFFFF, 32'h0, 32'h0, 5'h10);
    run(OP_FTOI, 3'h1, 2'b00, 32'h40400000, 32'h0, 32'h3);
    run(OP_FTOI, 3'h4, 2'b00, 32'h00400000, 32'h0, 32'h0, 5'h01);
    run(OP_FTOI, 3'h1, 2'b11, 32'hFF7FFFFF, 32'h0, 32'h80000000, 5'h10);
    run(OP_FTOI, 3'h4, 2'b00, 32'h7F800000, 32'h0, 32'h7FFFFFFF, 5'h10);
    run(OP_FTOI, 3'h1, 2'b00, 32'hFFFFFFFF, 32'h0, 32'h0, 5'h10);
    run(OP_FTOI, 3'h4, 2'b00, 32'hFFBFFFFF, 32'h0, 32'h0, 5'h10);
    @(posedge clk);
    extFlagsValid <= 1'b1;
    extFlags <= fflags_s'(5'h08);
    @(posedge clk);
    extFlagsValid <= 1'b0;
    fExp = fExp | 5'h08;
    run(OP_CARRY, 3'h3, 2'b00, 32'hFFFFFFFF, 32'h1, 32'h1);
    end_sim();
  end
endmodule // guarded_ops_unit_tb
